// ---- hdl/cci_exec_unit.sv ----
// Execution unit for control and packed-decimal conversion instructions.
// Summary of operation
// - No-operation changes only the program address, reads no operands.
// - No-operation advances program address by four.
// - Extended read copies extended to general register.
// - Bit 12 selects extended read or write.
// - First-group extended access traps instead.
// - Service request carries flagged request index byte.
// - Service request sets executing condition bit 13.
// - Service request sets state 4 busy, active unless state 4 issues it.
// - Service request clears executing busy, active.
// - Short convert: 3-byte packed into 16-bit register.
// - Short operand: five digits, sign, MSB first.
// - Short overflow beyond 32767 sets bit 0 only.
// - Long convert: 6-byte packed into 32 bits.
// - Pair result high first, register 7 wraps.
// - Long overflow beyond 2^31-1 sets bit 0 only.
// - Short decimal: 16-bit register to 3-byte packed.
// - Bit 12 set gives 6-byte decimal from pair.
`default_nettype none
module cci_exec_unit
	import cci_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	timeunit 1ns;
	timeprecision 1ps;
	function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8+:8] = n[i*8+:8];
			end
		end
		return r;
	endfunction : be_merge

	function automatic logic [39:0] mul10_add(input logic [39:0] a, input logic [3:0] d);
		return {a[36:0], 3'b000} + {a[38:0], 1'b0} + {36'h0, d};
	endfunction : mul10_add

	function automatic logic [43:0] dabble(input logic [43:0] b);
		logic [43:0] r;
		r = b;
		for (int i = 0; i < 11; i++) begin
			if (r[i*4+:4] >= 4'h5) begin
				r[i*4+:4] = r[i*4+:4] + 4'h3;
			end
		end
		return r;
	endfunction : dabble

	cci_state_e st;
	logic [15:0] ir;
	logic [15:0] pc;
	logic [15:0] cond [8];
	logic [15:0] gr [8];
	logic [15:0] ext [8];
	logic [2:0] cur;
	logic [7:0] busy;
	logic [7:0] active;
	logic [47:0] mem;
	logic [7:0] req_idx;
	logic trap;
	logic [5:0] cnt;
	logic [39:0] acc;
	logic [47:0] sh;
	logic [43:0] bcd;
	logic [31:0] bin;
	logic neg;
	logic [31:0] rd_mux;

	// Instruction fields; bit 0 of the instruction is the vector MSB.
	wire logic [7:0] op = ir[15:8];
	wire logic [2:0] f_r1 = ir[6:4];
	wire logic f_ext = ir[3];
	wire logic [2:0] f_r2 = ir[2:0];
	wire logic [2:0] r2n = f_r2 + 3'h1;
	wire logic grp1 = EXT_GROUP1[f_r1];
	wire logic dec = (st == ST_DEC);
	wire logic wr = avs_write && !avs_waitrequest;
	wire logic launch = wr && (avs_address == REG_INSTR);
	wire logic [31:0] wd = be_merge(rd_mux, avs_writedata, avs_byteenable);
	wire logic p2b_done = (st == ST_P2B) && (cnt == 6'h00);
	wire logic b2p_done = (st == ST_B2P) && (cnt == 6'h00);
	wire logic [39:0] res = neg ? (40'h0 - acc) : acc;
	// Magnitude compare keeps -32768 and -2^31 exact while still flagging them.
	wire logic ovf = f_ext ? (acc > MAX_LONG) : (acc > MAX_SHORT);
	wire logic [3:0] p2b_sign = f_ext ? mem[3:0] : mem[27:24];
	wire logic [31:0] v32 = f_ext ? {gr[f_r2], gr[r2n]} : {{16{gr[f_r2][15]}}, gr[f_r2]};
	wire logic [3:0] b2p_sign = neg ? SIGN_NEG : SIGN_POS;
	wire logic [43:0] bcd_adj = dabble(bcd);

	always_comb begin
		rd_mux = 32'h0;
		case (avs_address)
			REG_INSTR: rd_mux = {16'h0, ir};
			REG_STATUS: rd_mux = {31'h0, trap};
			REG_PC: rd_mux = {16'h0, pc};
			REG_COND: rd_mux = {16'h0, cond[cur]};
			REG_STATE: rd_mux = {29'h0, cur};
			REG_FLAGS: rd_mux = {16'h0, active, busy};
			REG_MEMHI: rd_mux = {16'h0, mem[47:32]};
			REG_MEMLO: rd_mux = mem[31:0];
			REG_REQIDX: rd_mux = {24'h0, req_idx};
			default: begin
				if (avs_address[7:5] == REG_GR_BASE) begin
					rd_mux = {16'h0, gr[avs_address[4:2]]};
				end else if (avs_address[7:5] == REG_EXT_BASE) begin
					rd_mux = {16'h0, ext[avs_address[4:2]]};
				end
			end
		endcase
	end

	// Accesses stall while an instruction runs, so bus and execution never write together.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && st == ST_IDLE) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= rd_mux;
		end
	end

	// Sequencing and conversion datapath.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= ST_IDLE;
			cnt <= 6'h00;
			acc <= 40'h0;
			sh <= 48'h0;
			bcd <= 44'h0;
			bin <= 32'h0;
			neg <= 1'b0;
		end else begin
			case (st)
				ST_IDLE: begin
					if (launch) begin
						st <= ST_DEC;
					end
				end
				ST_DEC: begin
					if (op == OP_P2B) begin
						st <= ST_P2B;
						acc <= 40'h0;
						sh <= f_ext ? mem : {mem[47:24], 24'h0};
						cnt <= f_ext ? P2B_LONG_DIGITS : P2B_SHORT_DIGITS;
						neg <= (p2b_sign == SIGN_NEG) || (p2b_sign == SIGN_NEG_ALT);
					end else if (op == OP_B2P) begin
						st <= ST_B2P;
						bcd <= 44'h0;
						bin <= v32[31] ? (32'h0 - v32) : v32;
						neg <= v32[31];
						cnt <= B2P_STEPS;
					end else begin
						st <= ST_IDLE;
					end
				end
				ST_P2B: begin
					if (cnt == 6'h00) begin
						st <= ST_IDLE;
					end else begin
						acc <= mul10_add(acc, sh[47:44]);
						sh <= {sh[43:0], 4'h0};
						cnt <= cnt - 6'h01;
					end
				end
				ST_B2P: begin
					if (cnt == 6'h00) begin
						st <= ST_IDLE;
					end else begin
						bcd <= {bcd_adj[42:0], bin[31]};
						bin <= {bin[30:0], 1'b0};
						cnt <= cnt - 6'h01;
					end
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// Architectural state: bus writes while idle, instruction results otherwise.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ir <= 16'h0;
			pc <= PC_RESET;
			cur <= 3'h0;
			busy <= FLAGS_RESET;
			active <= FLAGS_RESET;
			mem <= 48'h0;
			req_idx <= 8'h00;
			trap <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				cond[i] <= COND_RESET;
				gr[i] <= 16'h0;
				ext[i] <= 16'h0;
			end
		end else begin
			if (wr) begin
				case (avs_address)
					REG_INSTR: ir <= wd[15:0];
					REG_STATUS: begin
						if (avs_byteenable[0] && avs_writedata[0]) begin
							trap <= 1'b0;
						end
					end
					REG_PC: pc <= wd[15:0];
					REG_COND: cond[cur] <= wd[15:0];
					REG_STATE: cur <= wd[2:0];
					REG_FLAGS: begin
						busy <= wd[7:0];
						active <= wd[15:8];
					end
					REG_MEMHI: mem[47:32] <= wd[15:0];
					REG_MEMLO: mem[31:0] <= wd;
					default: begin
						if (avs_address[7:5] == REG_GR_BASE) begin
							gr[avs_address[4:2]] <= wd[15:0];
						end else if (avs_address[7:5] == REG_EXT_BASE) begin
							ext[avs_address[4:2]] <= wd[15:0];
						end
					end
				endcase
			end
			if (dec) begin
				case (op)
					OP_NOP: pc <= pc + LEN_NOP;
					OP_EXT: begin
						if (grp1) begin
							trap <= 1'b1;
							pc <= TRAP_ADDR;
						end else begin
							if (f_ext) begin
								ext[f_r1] <= gr[f_r2];
							end else begin
								gr[f_r2] <= ext[f_r1];
							end
							pc <= pc + LEN_RR;
						end
					end
					OP_SVC: begin
						req_idx <= ir[7:0];
						cond[cur][CB_SVC] <= 1'b1;
						busy[SVC_STATE] <= 1'b1;
						active[SVC_STATE] <= 1'b1;
						// If state 4 itself issues the request, the clear is applied last.
						busy[cur] <= 1'b0;
						active[cur] <= 1'b0;
						pc <= pc + LEN_RR;
					end
					OP_P2B, OP_B2P: pc <= pc + LEN_RX;
					default: begin
						trap <= 1'b1;
						pc <= TRAP_ADDR;
					end
				endcase
			end
			if (p2b_done) begin
				cond[cur][CB_OVF] <= ovf;
				if (f_ext) begin
					gr[f_r2] <= res[31:16];
					gr[r2n] <= res[15:0];
				end else begin
					gr[f_r2] <= res[15:0];
				end
			end
			if (b2p_done) begin
				if (f_ext) begin
					mem <= {bcd, b2p_sign};
				end else begin
					mem[47:24] <= {bcd[19:0], b2p_sign};
				end
			end
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	nop_quiet_a: assert property (dec && op == OP_NOP |=> $stable(busy) && $stable(active)
		&& $stable(mem) && $stable(trap) && $stable(cond[cur]))
		else $error("no-operation changed state");
	nop_pc_step_a: assert property (dec && op == OP_NOP |=> pc == $past(pc) + LEN_NOP)
		else $error("no-operation pc step wrong");
	ext_read_a: assert property (dec && op == OP_EXT && !f_ext && !grp1
		|=> gr[f_r2] == $past(ext[f_r1]))
		else $error("extended read copy wrong");
	ext_write_a: assert property (dec && op == OP_EXT && f_ext && !grp1
		|=> ext[f_r1] == $past(gr[f_r2]))
		else $error("extended write copy wrong");
	grp1_trap_a: assert property (dec && op == OP_EXT && grp1
		|=> trap && pc == TRAP_ADDR && $stable(gr[f_r2]) && $stable(ext[f_r1]))
		else $error("protected access did not trap");
	svc_cond_a: assert property (dec && op == OP_SVC |=> cond[cur][CB_SVC])
		else $error("service bit not set");
	svc_flags_a: assert property (dec && op == OP_SVC && cur != SVC_STATE
		|=> busy[SVC_STATE] && active[SVC_STATE] && !busy[cur] && !active[cur])
		else $error("service flags wrong");
	p2b_keep_a: assert property (p2b_done |=> cond[cur][14:8] == $past(cond[cur][14:8]))
		else $error("condition bits 1-7 changed");
	p2b_short_time_a: assert property (dec && op == OP_P2B && !f_ext
		|-> ##6 p2b_done ##1 st == ST_IDLE)
		else $error("short convert timing wrong");
	p2b_wrap_a: assert property (p2b_done && f_ext && f_r2 == 3'h7
		|=> gr[0] == $past(res[15:0]) && gr[7] == $past(res[31:16]))
		else $error("register pair wrap wrong");
	b2p_sign_a: assert property (b2p_done && !f_ext
		|=> mem[27:24] == ($past(neg) ? SIGN_NEG : SIGN_POS))
		else $error("packed sign wrong");

	nop_run_c: cover property (dec && op == OP_NOP);
	svc_run_c: cover property (dec && op == OP_SVC);
	p2b_ovf_c: cover property (p2b_done && ovf);
	b2p_long_c: cover property (b2p_done && f_ext);
endmodule : cci_exec_unit
`default_nettype wire

// ---- include/cci_pkg.sv ----
// Constants, register map and state encoding for the control and convert unit.
`default_nettype none
package cci_pkg;
	// Opcodes (instruction bits 0-7).
	localparam logic [7:0] OP_NOP = 8'hee;
	localparam logic [7:0] OP_EXT = 8'hf0;
	localparam logic [7:0] OP_SVC = 8'h13;
	localparam logic [7:0] OP_P2B = 8'haa;
	localparam logic [7:0] OP_B2P = 8'hab;
	// Program address steps and trap target.
	localparam logic [15:0] LEN_NOP = 16'h0004;
	localparam logic [15:0] LEN_RR = 16'h0002;
	localparam logic [15:0] LEN_RX = 16'h0004;
	localparam logic [15:0] TRAP_ADDR = 16'h0100;
	localparam logic [15:0] PC_RESET = 16'h0000;
	// Extended registers whose bit is set here form the protected first group.
	localparam logic [7:0] EXT_GROUP1 = 8'hf0;
	localparam logic [2:0] SVC_STATE = 3'h4;
	// Condition bit positions; architectural bit n sits at vector bit 15-n.
	localparam int CB_OVF = 15;
	localparam int CB_SVC = 2;
	localparam logic [15:0] COND_RESET = 16'h0000;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	// Packed decimal signs.
	localparam logic [3:0] SIGN_POS = 4'hc;
	localparam logic [3:0] SIGN_NEG = 4'hd;
	localparam logic [3:0] SIGN_NEG_ALT = 4'hb;
	// Iteration counts.
	localparam logic [5:0] P2B_SHORT_DIGITS = 6'h05;
	localparam logic [5:0] P2B_LONG_DIGITS = 6'h0b;
	localparam logic [5:0] B2P_STEPS = 6'h20;
	localparam logic [39:0] MAX_SHORT = 40'h0000007fff;
	localparam logic [39:0] MAX_LONG = 40'h007fffffff;
	// Register byte offsets.
	localparam logic [7:0] REG_INSTR = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PC = 8'h08;
	localparam logic [7:0] REG_COND = 8'h0c;
	localparam logic [7:0] REG_STATE = 8'h10;
	localparam logic [7:0] REG_FLAGS = 8'h14;
	localparam logic [7:0] REG_MEMHI = 8'h18;
	localparam logic [7:0] REG_MEMLO = 8'h1c;
	localparam logic [7:0] REG_REQIDX = 8'h20;
	localparam logic [2:0] REG_GR_BASE = 3'h2;
	localparam logic [2:0] REG_EXT_BASE = 3'h3;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DEC = 4'h2,
		ST_P2B = 4'h4,
		ST_B2P = 4'h8
	} cci_state_e;
endpackage : cci_pkg
`default_nettype wire

// ---- testbench/control_and_convert_instr_tb.sv ----
// Self-checking bench for the control and convert execution unit.
`default_nettype none
module control_and_convert_instr_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cci_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	int num_errors = 0;
	int n_compared = 0;

	cci_exec_unit uut (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest)
	);

	always #2 sys_clk = ~sys_clk;

	task automatic results();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	// The extra edge after release keeps a following request off the same time step.
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] q);
		int i;
		avs_address <= a;
		avs_read <= rd;
		avs_write <= ~rd;
		avs_writedata <= wd;
		for (i = 0; i < 400; i++) begin
			@(posedge sys_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i == 400) begin
			num_errors++;
			results();
		end
		@(posedge sys_clk);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b0, a, d, q);
	endtask : wr

	task automatic chk(input string name, input logic [7:0] a, input logic [31:0] exp,
			input logic [31:0] m = 32'hffffffff);
		logic [31:0] q;
		bus(1'b1, a, 32'h0, q);
		n_compared++;
		if ((q & m) !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, q & m);
			num_errors++;
		end
	endtask : chk

	task automatic t_nop();
		wr(8'h44, 32'h1234);
		wr(REG_PC, 32'h0010);
		wr(REG_INSTR, 32'hee00);
		chk("pc", REG_PC, 32'h0014);
		chk("gr1", 8'h44, 32'h1234);
		chk("cond", REG_COND, 32'h0);
		chk("status", REG_STATUS, 32'h0);
		wr(8'h3c, 32'hffffffff);
		chk("unmapped", 8'h3c, 32'h0);
	endtask : t_nop

	task automatic t_ext();
		wr(8'h68, 32'h5a5a);
		wr(REG_INSTR, 32'hf025);
		chk("gr5", 8'h54, 32'h5a5a);
		wr(REG_INSTR, 32'hf03d);
		chk("ext3", 8'h6c, 32'h5a5a);
		wr(REG_INSTR, 32'hf041);
		chk("trap", REG_STATUS, 32'h1);
		chk("trap pc", REG_PC, 32'h0100);
		chk("gr1", 8'h44, 32'h1234);
		wr(REG_STATUS, 32'h1);
		wr(REG_INSTR, 32'hf059);
		chk("ext5", 8'h74, 32'h0);
		chk("trap", REG_STATUS, 32'h1);
		wr(REG_STATUS, 32'h1);
		chk("trap clr", REG_STATUS, 32'h0);
	endtask : t_ext

	task automatic t_svc();
		logic [3:0] c;
		wr(REG_STATE, 32'h2);
		wr(REG_FLAGS, 32'h0404);
		wr(REG_COND, 32'h0);
		wr(REG_INSTR, 32'h13a5);
		chk("cond", REG_COND, 32'h0004);
		chk("flags", REG_FLAGS, 32'h1010);
		chk("index", REG_REQIDX, 32'ha5);
		for (c = 4'h0; c < 4'h7; c++) begin
			wr(REG_INSTR, {16'h0, 8'h13, 4'h8, c});
			chk("index", REG_REQIDX, {24'h0, 4'h8, c});
		end
	endtask : t_svc

	// Condition bits 1 and 3 are preset to show that only bit 0 moves.
	task automatic p2b(input logic [15:0] hi, input logic [31:0] lo, input logic [15:0] ins,
			input logic [7:0] ra, input logic [7:0] rb, input logic [31:0] v, input logic ovf);
		wr(REG_COND, 32'h5000);
		wr(REG_MEMHI, {16'h0, hi});
		wr(REG_MEMLO, lo);
		wr(REG_INSTR, {16'h0, ins});
		chk("cond", REG_COND, {16'h0, ovf, 15'h5000});
		if (ins[3]) begin
			chk("high half", ra, {16'h0, v[31:16]});
			chk("low half", rb, {16'h0, v[15:0]});
		end else begin
			chk("short", ra, {16'h0, v[15:0]});
		end
	endtask : p2b

	task automatic b2p(input logic [15:0] ins, input logic [7:0] ra, input logic [15:0] va,
			input logic [7:0] rb, input logic [15:0] vb, input logic [31:0] eh,
			input logic [31:0] el, input logic [31:0] m);
		wr(ra, {16'h0, va});
		wr(rb, {16'h0, vb});
		wr(REG_INSTR, {16'h0, ins});
		chk("packed hi", REG_MEMHI, eh);
		chk("packed lo", REG_MEMLO, el, m);
	endtask : b2p

	task automatic t_conv();
		p2b(16'h1234, 32'h5c000000, 16'haa03, 8'h4c, 8'h00, 32'h3039, 1'b0);
		p2b(16'h3276, 32'h7c000000, 16'haa03, 8'h4c, 8'h00, 32'h7fff, 1'b0);
		p2b(16'h3276, 32'h7d000000, 16'haa03, 8'h4c, 8'h00, 32'h8001, 1'b0);
		p2b(16'h3276, 32'h8d000000, 16'haa03, 8'h4c, 8'h00, 32'h8000, 1'b1);
		p2b(16'h0214, 32'h7483648d, 16'haa0f, 8'h5c, 8'h40, 32'h80000000, 1'b1);
		p2b(16'h0214, 32'h7483647c, 16'haa09, 8'h44, 8'h48, 32'h7fffffff, 1'b0);
		b2p(16'hab02, 8'h48, 16'h7fff, 8'h48, 16'h7fff, 32'h3276, 32'h7c000000,
			32'hff000000);
		b2p(16'hab02, 8'h48, 16'hfffe, 8'h48, 16'hfffe, 32'h0000, 32'h2d000000,
			32'hff000000);
		b2p(16'hab0f, 8'h5c, 16'h7fff, 8'h40, 16'hffff, 32'h0214, 32'h7483647c,
			32'hffffffff);
		b2p(16'hab0f, 8'h5c, 16'h8000, 8'h40, 16'h0001, 32'h0214, 32'h7483647d,
			32'hffffffff);
	endtask : t_conv

	initial begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		t_nop();
		t_ext();
		t_svc();
		t_conv();
		results();
	end
endmodule : control_and_convert_instr_tb
`default_nettype wire
